//--- bench/trtc_osc_model.sv
`timescale 1ns/1ps

module trtc_osc_model #(
    parameter int HALF_CYC = 4
) (
    input  wire logic ref_clk_in,
    input  wire logic run_in,
    output logic      osc_out
);
    logic [7:0] phase_reg;

    always_ff @(posedge ref_clk_in)
    begin
        if (run_in && phase_reg != 8'(2 * HALF_CYC - 1))
            phase_reg <= phase_reg + 8'h01;
        else
            phase_reg <= 8'h00;
    end

    // A stopped crystal holds its output low, so no stale level can look like an edge.
    assign osc_out = run_in && (phase_reg >= 8'(HALF_CYC));
endmodule : trtc_osc_model

//--- bench/trtc_timer_tb.sv
`timescale 1ns/1ps

module trtc_timer_tb;
    localparam int HALF = 4;
    logic                  ref_clk_in = 1'b0;
    logic                  rstn_in    = 1'b0;
    logic                  osc_en     = 1'b0;
    logic                  sleep_r    = 1'b0;
    logic                  idle_r     = 1'b0;
    trtc_pkg::trtc_wb_req_s req       = '0;
    logic                  lp_osc;
    logic [31:0]           rd_dat;
    logic [31:0]           rd;
    logic                  ack;
    logic                  irq;
    logic                  wake;
    int                    failures   = 0;
    int                    num_checks = 0;
    int                    cyc_cnt    = 0;

    always #5 ref_clk_in = ~ref_clk_in;

    trtc_osc_model #(.HALF_CYC(HALF)) trtc_osc_model_inst (.ref_clk_in(ref_clk_in),
        .run_in(osc_en), .osc_out(lp_osc));

    trtc_timer trtc_timer_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .lp_osc_in(lp_osc),
        .cpu_sleep_in(sleep_r), .cpu_idle_in(idle_r), .wb_adr_in(req.adr), .wb_dat_in(req.dat),
        .wb_sel_in(req.sel), .wb_we_in(req.we), .wb_cyc_in(req.cyc), .wb_stb_in(req.stb),
        .wb_dat_out(rd_dat), .wb_ack_out(ack), .irq_out(irq), .wake_out(wake));

    // ==========================================================
    // Bus, oscillator and check tasks
    // ==========================================================
    task automatic finish_test();
        if (failures == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
            failures++;
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        req <= '{adr: a, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
        do @(posedge ref_clk_in); while (ack !== 1'b1);
        rd = rd_dat;
        req <= '0;
    endtask : wb

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rdc

    // Pins are looked at mid-cycle, once the edge that wrote their enable has settled.
    task automatic chk_pins(input logic [1:0] e);
        @(negedge ref_clk_in);
        chk({30'h0, wake, irq}, {30'h0, e});
    endtask : chk_pins

    // The crystal runs for whole periods only, so the edge count is exact.
    task automatic edges(input int k);
        @(posedge ref_clk_in);
        osc_en <= 1'b1;
        repeat (k * 2 * HALF) @(posedge ref_clk_in);
        osc_en <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
    endtask : edges

    always @(posedge ref_clk_in)
    begin
        cyc_cnt++;
        if (cyc_cnt == 5000)
        begin
            failures++;
            finish_test();
        end
    end

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial
    begin
        repeat (6) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        rdc(trtc_pkg::PERIOD_OFS, 32'h0000_FFFF);
        rdc(trtc_pkg::PSC_OFS, 32'h0000_0000);
        rdc(8'h20, 32'h0000_0000);
        wb(1'b1, trtc_pkg::COUNT_OFS, 32'h0000_0000);
        wb(1'b1, trtc_pkg::CTRL_OFS, 32'h0000_0003);
        edges(5);
        rdc(trtc_pkg::COUNT_OFS, 32'h0000_0005);
        wb(1'b1, trtc_pkg::CTRL_OFS, 32'h0000_0007);
        edges(3);
        rdc(trtc_pkg::COUNT_OFS, 32'h0000_0005);
        wb(1'b1, trtc_pkg::CTRL_OFS, 32'h0000_0001);
        edges(2);
        rdc(trtc_pkg::COUNT_OFS, 32'h0000_0005);
        idle_r <= 1'b1;
        wb(1'b1, trtc_pkg::CTRL_OFS, 32'h0000_0013);
        edges(2);
        rdc(trtc_pkg::COUNT_OFS, 32'h0000_0005);
        sleep_r <= 1'b1;
        wb(1'b1, trtc_pkg::CTRL_OFS, 32'h0000_0003);
        edges(2);
        rdc(trtc_pkg::COUNT_OFS, 32'h0000_0007);
        wb(1'b1, trtc_pkg::CTRL_OFS, 32'h0000_0000);
        wb(1'b1, trtc_pkg::PSC_OFS, 32'h0000_0001);
        wb(1'b1, trtc_pkg::COUNT_OFS, 32'h0000_0000);
        wb(1'b1, trtc_pkg::CTRL_OFS, 32'h0000_0003);
        edges(6);
        rdc(trtc_pkg::COUNT_OFS, 32'h0000_0003);
        wb(1'b1, trtc_pkg::CTRL_OFS, 32'h0000_0000);
        wb(1'b1, trtc_pkg::PSC_OFS, 32'h0000_0000);
        wb(1'b1, trtc_pkg::PERIOD_OFS, 32'h0000_0003);
        wb(1'b1, trtc_pkg::COUNT_OFS, 32'h0000_0000);
        wb(1'b1, trtc_pkg::IEN_OFS, 32'h0000_0001);
        wb(1'b1, trtc_pkg::CTRL_OFS, 32'h0000_0003);
        edges(3);
        rdc(trtc_pkg::COUNT_OFS, 32'h0000_0003);
        rdc(trtc_pkg::STAT_OFS, 32'h0000_0000);
        edges(1);
        rdc(trtc_pkg::COUNT_OFS, 32'h0000_0000);
        rdc(trtc_pkg::STAT_OFS, 32'h0000_0001);
        chk_pins(2'b01);
        edges(1);
        wb(1'b1, trtc_pkg::CTRL_OFS, 32'h0000_0000);
        rdc(trtc_pkg::STAT_OFS, 32'h0000_0001);
        wb(1'b1, trtc_pkg::ICLR_OFS, 32'h0000_0001);
        rdc(trtc_pkg::STAT_OFS, 32'h0000_0000);
        rdc(trtc_pkg::ICLR_OFS, 32'h0000_0000);
        wb(1'b1, trtc_pkg::IEN_OFS, 32'h0000_0000);
        wb(1'b1, trtc_pkg::COUNT_OFS, 32'h0000_0003);
        wb(1'b1, trtc_pkg::CTRL_OFS, 32'h0000_0003);
        edges(1);
        rdc(trtc_pkg::STAT_OFS, 32'h0000_0001);
        chk_pins(2'b00);
        wb(1'b1, trtc_pkg::IEN_OFS, 32'h0000_0001);
        chk_pins(2'b01);
        wb(1'b1, trtc_pkg::CTRL_OFS, 32'h0000_0000);
        wb(1'b1, trtc_pkg::ICLR_OFS, 32'h0000_0003);
        wb(1'b1, trtc_pkg::OSC_OFS, 32'h0000_0002);
        wb(1'b1, trtc_pkg::IEN_OFS, 32'h0000_0002);
        wb(1'b1, trtc_pkg::CTRL_OFS, 32'h0000_0003);
        edges(4);
        rdc(trtc_pkg::STAT_OFS, 32'h0000_0002);
        chk_pins(2'b11);
        wb(1'b1, trtc_pkg::ICLR_OFS, 32'h0000_0002);
        rdc(trtc_pkg::STAT_OFS, 32'h0000_0000);
        wb(1'b1, trtc_pkg::COUNT_OFS, 32'h0000_FFFF);
        edges(1);
        rdc(trtc_pkg::COUNT_OFS, 32'h0000_0000);
        rdc(trtc_pkg::STAT_OFS, 32'h0000_0002);
        finish_test();
    end
endmodule : trtc_timer_tb

//--- common/trtc_pkg.sv
package trtc_pkg;

    // ==========================================================
    // Register map (byte addresses, one 32-bit word each)
    // ==========================================================
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] PERIOD_OFS = 8'h04;
    localparam logic [7:0] COUNT_OFS  = 8'h08;
    localparam logic [7:0] OSC_OFS    = 8'h0C;
    localparam logic [7:0] STAT_OFS   = 8'h10;
    localparam logic [7:0] IEN_OFS    = 8'h14;
    localparam logic [7:0] ICLR_OFS   = 8'h18;
    localparam logic [7:0] PSC_OFS    = 8'h1C;

    // ==========================================================
    // Control, oscillator, status and event fields
    // ==========================================================
    localparam int CTRL_ON_BIT    = 0;
    localparam int CTRL_CSS_BIT   = 1;
    localparam int CTRL_GATE_BIT  = 2;
    localparam int CTRL_SYNC_BIT  = 3;
    localparam int CTRL_SIDL_BIT  = 4;
    localparam int OSC_LPEN_BIT   = 1;
    localparam int STAT_PER_BIT   = 0;
    localparam int STAT_WAKE_BIT  = 1;
    localparam int NUM_EVENTS     = 2;

    localparam logic [15:0] PERIOD_RST = 16'hFFFF;
    localparam logic [7:0]  PSC_RST    = 8'h00;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    typedef struct packed {
        logic stop_in_idle;
        logic external_sync_select;
        logic gate_accumulate_enable;
        logic clock_source_select;
        logic timer_on;
    } trtc_ctrl_s;

    typedef struct packed {
        logic [7:0]  adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } trtc_wb_req_s;

endpackage : trtc_pkg

//--- hw/trtc_timer.sv
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// - Count oscillator rising edges when on, external, ungated.
// - Count to period, then wrap to zero.
// - Low power enable gives wake event on period wrap or carry-out.
// - Counter keeps running during processor sleep.
// - Idle stops counting only when stop_in_idle set.
// - Period event sets sticky timer irq flag.
// - Flag clears only by software write.
// - Interrupt forwarded only when flag enabled.
// - Event raised when count equals period.
module trtc_timer #(
    parameter int CNT_W = 16,
    parameter int PSC_W = 8
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        lp_osc_in,
    input  wire logic        cpu_sleep_in,
    input  wire logic        cpu_idle_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [31:0] wb_dat_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic        wb_we_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    output logic [31:0]      wb_dat_out,
    output logic             wb_ack_out,
    output logic             irq_out,
    output logic             wake_out
);

    // ==========================================================
    // Bus decode
    // ==========================================================
    trtc_pkg::trtc_wb_req_s req;
    assign req = '{adr: wb_adr_in, dat: wb_dat_in, sel: wb_sel_in, we: wb_we_in,
                   cyc: wb_cyc_in, stb: wb_stb_in};

    // A read is captured on the first edge of a request, while a write lands on the
    // edge at which the master samples ack high, so both ends agree on when it happened.
    wire logic acc    = req.cyc && req.stb && !wb_ack_out;
    wire logic rd_acc = acc && !req.we;
    wire logic wr     = req.cyc && req.stb && wb_ack_out && req.we;
    wire logic wr_lo  = wr && req.sel[0];
    wire logic wr_hi  = wr && req.sel[1];
    wire logic wr_ctl = wr_lo && req.adr == trtc_pkg::CTRL_OFS;
    wire logic wr_per = (wr_lo || wr_hi) && req.adr == trtc_pkg::PERIOD_OFS;
    wire logic wr_cnt = (wr_lo || wr_hi) && req.adr == trtc_pkg::COUNT_OFS;
    wire logic wr_osc = wr_lo && req.adr == trtc_pkg::OSC_OFS;
    wire logic wr_ien = wr_lo && req.adr == trtc_pkg::IEN_OFS;
    wire logic wr_clr = wr_lo && req.adr == trtc_pkg::ICLR_OFS;
    wire logic wr_psc = wr_lo && req.adr == trtc_pkg::PSC_OFS;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old_v[15:8], s[0] ? d[7:0] : old_v[7:0]};
    endfunction : merge16

    // ==========================================================
    // Registers
    // ==========================================================
    trtc_pkg::trtc_ctrl_s ctrl_reg;
    logic [CNT_W-1:0]     period_reg;
    logic [CNT_W-1:0]     count_reg;
    logic [CNT_W-1:0]     count_next;
    logic [PSC_W-1:0]     psc_lim_reg;
    logic [PSC_W-1:0]     psc_cnt_reg;
    logic [PSC_W-1:0]     psc_cnt_next;
    logic                 lpen_reg;
    logic [trtc_pkg::NUM_EVENTS-1:0] stat_reg;
    logic [trtc_pkg::NUM_EVENTS-1:0] stat_next;
    logic [trtc_pkg::NUM_EVENTS-1:0] evt_set;
    logic [trtc_pkg::NUM_EVENTS-1:0] evt_clr;
    logic [trtc_pkg::NUM_EVENTS-1:0] ien_reg;
    logic                 osc_d_reg;
    logic [31:0]          rdata;

    // The oscillator is treated as synchronous to ref_clk_in; one stage finds its edge.
    wire logic osc_rise = lp_osc_in && !osc_d_reg;

    // Idle halts the count only when software asked for it; sleep never does.
    wire logic idle_hold = cpu_idle_in && ctrl_reg.stop_in_idle;
    wire logic run = ctrl_reg.timer_on && ctrl_reg.clock_source_select
                     && !ctrl_reg.gate_accumulate_enable && !idle_hold;

    // The sync bit is stored but not acted on: correct operation needs it at zero.
    wire logic psc_tick = run && osc_rise && psc_cnt_reg == psc_lim_reg;
    wire logic at_period = count_reg == period_reg;
    wire logic cnt_wrap = psc_tick && at_period;
    wire logic carry    = psc_tick && count_reg == {CNT_W{1'b1}} && !at_period;

    // Low power mode trades the period event for a wake event, raised on a period wrap or on a carry-out.
    wire logic per_evt  = cnt_wrap && !lpen_reg;
    wire logic wake_evt = (cnt_wrap || carry) && lpen_reg;

    assign psc_cnt_next = !(run && osc_rise) ? psc_cnt_reg
                        : (psc_cnt_reg == psc_lim_reg) ? '0
                        : psc_cnt_reg + 1'b1;

    // A software load beats the increment, so a loaded value is never lost.
    assign count_next = wr_cnt ? merge16(count_reg, req.dat, req.sel)
                      : cnt_wrap ? '0
                      : psc_tick ? count_reg + 1'b1
                      : count_reg;

    // Events land at fixed bit positions, so status, enable and clear share one layout.
    always_comb
    begin
        evt_set                          = '0;
        evt_set[trtc_pkg::STAT_PER_BIT]  = per_evt;
        evt_set[trtc_pkg::STAT_WAKE_BIT] = wake_evt;
    end

    assign evt_clr = wr_clr ? req.dat[trtc_pkg::NUM_EVENTS-1:0] : '0;

    // Set wins over a software clear in the same cycle, so no event is ever lost.
    assign stat_next = (stat_reg & ~evt_clr) | evt_set;

    // The write-only clear register reads as zero through the default branch.
    always_comb
    begin
        case (req.adr)
            trtc_pkg::CTRL_OFS:   rdata = {27'h0, ctrl_reg};
            trtc_pkg::PERIOD_OFS: rdata = {16'h0, period_reg};
            trtc_pkg::COUNT_OFS:  rdata = {16'h0, count_reg};
            trtc_pkg::OSC_OFS:    rdata = {30'h0, lpen_reg, 1'b0};
            trtc_pkg::STAT_OFS:   rdata = {30'h0, stat_reg};
            trtc_pkg::IEN_OFS:    rdata = {30'h0, ien_reg};
            trtc_pkg::PSC_OFS:    rdata = {24'h0, psc_lim_reg};
            default:              rdata = trtc_pkg::UNMAPPED_RD;
        endcase
    end

    // ==========================================================
    // Oscillator edge and prescaler
    // ==========================================================
    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            osc_d_reg <= 1'b0;
        else
            osc_d_reg <= lp_osc_in;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            psc_cnt_reg <= '0;
        else
            psc_cnt_reg <= psc_cnt_next;
    end

    // ==========================================================
    // Counter and status
    // ==========================================================
    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            count_reg <= '0;
        else
            count_reg <= count_next;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            stat_reg <= '0;
        else
            stat_reg <= stat_next;
    end

    // ==========================================================
    // Bus answer
    // ==========================================================
    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            wb_ack_out <= 1'b0;
        else
            wb_ack_out <= acc;
    end

    // Read data is held until the next read, so a slow master still finds it.
    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            wb_dat_out <= '0;
        else if (rd_acc)
            wb_dat_out <= rdata;
    end

    // ==========================================================
    // Software registers
    // ==========================================================
    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            ctrl_reg <= '0;
        else if (wr_ctl)
            ctrl_reg <= trtc_pkg::trtc_ctrl_s'(req.dat[4:0]);
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            period_reg <= trtc_pkg::PERIOD_RST;
        else if (wr_per)
            period_reg <= merge16(period_reg, req.dat, req.sel);
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            lpen_reg <= 1'b0;
        else if (wr_osc)
            lpen_reg <= req.dat[trtc_pkg::OSC_LPEN_BIT];
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            ien_reg <= '0;
        else if (wr_ien)
            ien_reg <= req.dat[trtc_pkg::NUM_EVENTS-1:0];
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
            psc_lim_reg <= trtc_pkg::PSC_RST;
        else if (wr_psc)
            psc_lim_reg <= req.dat[PSC_W-1:0];
    end

    // ==========================================================
    // Interrupt and wake outputs
    // ==========================================================
    assign irq_out  = |(stat_reg & ien_reg);
    assign wake_out = stat_reg[trtc_pkg::STAT_WAKE_BIT];

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    a_count_wrap: assert property (cnt_wrap |=> count_reg == '0 || $past(wr_cnt))
        else $error("count did not wrap at period");
    a_count_step: assert property (psc_tick && !at_period && !wr_cnt
                                   |=> count_reg == $past(count_reg) + 1'b1)
        else $error("count did not advance on tick");
    a_gate_hold: assert property (ctrl_reg.gate_accumulate_enable && !wr_cnt
                                  |=> $stable(count_reg))
        else $error("count moved while gated");
    a_off_hold: assert property (!ctrl_reg.timer_on && !wr_cnt |=> $stable(count_reg))
        else $error("count moved while timer off");
    a_idle_hold: assert property (idle_hold && !wr_cnt |=> $stable(count_reg))
        else $error("count moved while held in idle");
    a_sleep_runs: assert property (cpu_sleep_in && psc_tick && !at_period && !wr_cnt
                                   |=> count_reg != $past(count_reg))
        else $error("count stopped in sleep");
    a_flag_set: assert property (per_evt |=> stat_reg[0])
        else $error("period flag not set");
    a_flag_sticky: assert property (stat_reg[0] && !(wr_clr && req.dat[0])
                                    |=> stat_reg[0])
        else $error("flag cleared without software");
    a_flag_clear: assert property (stat_reg[0] && wr_clr && req.dat[0] && !per_evt
                                   |=> !stat_reg[0])
        else $error("software clear did not take");
    a_irq_gate: assert property (irq_out
                                 |-> (stat_reg[0] && ien_reg[0]) || (stat_reg[1] && ien_reg[1]))
        else $error("irq not gated by enable");
    a_irq_raise: assert property (stat_reg[0] && ien_reg[0] |-> irq_out)
        else $error("enabled flag did not raise irq");
    a_lp_mode: assert property (lpen_reg && !$past(wr_clr) |=> !$rose(stat_reg[0]))
        else $error("period event in low power mode");
    a_wake_set: assert property (lpen_reg && (cnt_wrap || carry) |=> stat_reg[1])
        else $error("wake flag not set on carry");
    a_psc_reload: assert property (psc_tick |=> psc_cnt_reg == '0)
        else $error("prescaler did not reload after tick");
    a_match_evt: assert property ($rose(stat_reg[0])
                                  |-> $past(at_period) && !$past(lpen_reg))
        else $error("event without period match");

    // Bus handshake: one ack per request, read data captured with it.
    a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held for more than one cycle");
    a_ack_answer: assert property (acc |=> wb_ack_out)
        else $error("request not answered in one cycle");
    a_read_data: assert property (rd_acc |=> wb_dat_out == $past(rdata))
        else $error("read data not captured");

    // ==========================================================
    // Coverage
    // ==========================================================
    c_wrap: cover property (cnt_wrap);
    c_irq: cover property (per_evt ##1 irq_out);
    c_wake: cover property (wake_evt);
    c_carry: cover property (carry && lpen_reg);
    c_clear_race: cover property (per_evt && wr_clr);

endmodule : trtc_timer
